// [inc/pmc_map.svh]
/*
  offsets-free constant map of the controller-side port: symbol codes,
  widths and fifo depth. assumes nothing but being included once.
*/
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_NIB_W      4
`define PMC_SYM_W      5
`define PMC_FIFO_DEPTH 32
`define PMC_SYM_IDLE   5'h1f
`define PMC_SYM_HALT   5'h04
`define PMC_SYNC_LEN   3
`endif

// [inc/pmc_pkg.sv]
/*
  types and code functions of the controller-side port.
  assumes pmc_map.svh sits on the include path.
*/
`include "pmc_map.svh"
package pmc_pkg;
  typedef logic [`PMC_NIB_W-1:0] pmc_nib_t;
  typedef logic [`PMC_SYM_W-1:0] pmc_sym_t;
  // received item: fifth bit is error flag, or data bit in bypass
  typedef struct packed {
    logic     fifth;
    pmc_nib_t nib;
  } pmc_rx_item_t;

  // -----------------------------------------------------------------
  // block code table
  // -----------------------------------------------------------------
  function automatic pmc_sym_t pmc_encode(input pmc_nib_t n);
    pmc_sym_t tbl [16];
    tbl = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
            5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    return tbl[n];
  endfunction : pmc_encode

  // returns {invalid, nibble}
  function automatic logic [`PMC_NIB_W:0] pmc_decode(input pmc_sym_t s);
    logic [`PMC_NIB_W:0] r;
    r = {1'b1, 4'h0};
    for (int i = 0; i < 16; i++) begin
      if (pmc_encode(4'(i)) == s) begin
        r = {1'b0, 4'(i)};
      end
    end
    return r;
  endfunction : pmc_decode
endpackage : pmc_pkg

// [design/pmc_mii_port.sv]
/*
  controller-side media independent port of the line interface:
  gray-pointer fifo and the port top. assumes the reference clock is
  a free running 25 MHz clock and that the line logic runs on clk_i.
*/
`timescale 1ns/1ps

// -------------------------------------------------------------------
// dual clock fifo
// -------------------------------------------------------------------
module pmc_async_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 32
) (
  input  wire logic             wclk_i,
  input  wire logic             rclk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             wvalid_i,
  output logic                  wready_o,
  output logic [WIDTH-1:0]      rdata_o,
  output logic                  rvalid_o,
  input  wire logic             rready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wbin_reg, rbin_reg, wgray_reg, rgray_reg;
  logic [AW:0]      rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
  logic [AW:0]      wbin_next, rbin_next;
  logic             push, pop;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  // full compares against read pointer with top two bits inverted
  assign wready_o  = wgray_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
  assign rvalid_o  = rgray_reg != wg_s2_reg;
  assign push      = wvalid_i && wready_o;
  assign pop       = rvalid_o && rready_i;
  assign wbin_next = wbin_reg + (AW+1)'(push);
  assign rbin_next = rbin_reg + (AW+1)'(pop);
  assign rdata_o   = mem_reg[rbin_reg[AW-1:0]];

  always_ff @(posedge wclk_i) begin
    if (push) begin
      mem_reg[wbin_reg[AW-1:0]] <= wdata_i;
    end
  end

  always_ff @(posedge wclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      wbin_reg  <= wbin_next;
      wgray_reg <= bin2gray(wbin_next);
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end

  always_ff @(posedge rclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end else begin
      rbin_reg  <= rbin_next;
      rgray_reg <= bin2gray(rbin_next);
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
    end
  end
endmodule : pmc_async_fifo

// -------------------------------------------------------------------
// port top
// -------------------------------------------------------------------
module pmc_mii_port (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire logic               reference_clock_input_i,
  input  wire logic               encoder_bypass_i,
  input  wire logic               decoder_bypass_i,
  output logic                    tx_clk_o,
  input  wire pmc_pkg::pmc_nib_t  txd_i,
  input  wire logic               tx_en_i,
  input  wire logic               tx_er_i,
  output logic                    rx_clk_o,
  output pmc_pkg::pmc_nib_t       rxd_o,
  output logic                    rx_dv_o,
  output logic                    rx_er_o,
  output logic                    crs_o,
  output logic                    col_o,
  output pmc_pkg::pmc_sym_t       line_tx_sym_o,
  output logic                    line_tx_active_o,
  input  wire pmc_pkg::pmc_sym_t  line_rx_sym_i,
  input  wire logic               line_rx_valid_i,
  output logic                    line_rx_ready_o,
  input  wire logic               line_rx_carrier_i
);
  import pmc_pkg::*;

  logic [`PMC_SYNC_LEN-1:0] enc_sync_reg, dec_sync_reg, crs_sync_reg;
  logic                     enc_byp_reg, dec_byp_reg;
  logic                     rx_clk_n;
  pmc_rx_item_t             push_item, pop_item;
  logic                     pop_valid;
  logic [`PMC_NIB_W:0]      dec_res;

  // ---------------------------------------------------------------
  // clocks
  // ---------------------------------------------------------------
  // both port clocks are the reference itself, no divider needed
  assign tx_clk_o = reference_clock_input_i;
  assign rx_clk_o = reference_clock_input_i;
  // falling edge domain as an inverted clock for the fifo read side
  assign rx_clk_n = ~reference_clock_input_i;

  // ---------------------------------------------------------------
  // strap synchronisers; change accepted once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge reference_clock_input_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enc_sync_reg <= '0;
      enc_byp_reg  <= 1'b0;
    end else begin
      enc_sync_reg <= {enc_sync_reg[1:0], encoder_bypass_i};
      if (enc_sync_reg[1] == enc_sync_reg[2]) begin
        enc_byp_reg <= enc_sync_reg[2];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dec_sync_reg <= '0;
      dec_byp_reg  <= 1'b0;
    end else begin
      dec_sync_reg <= {dec_sync_reg[1:0], decoder_bypass_i};
      if (dec_sync_reg[1] == dec_sync_reg[2]) begin
        dec_byp_reg <= dec_sync_reg[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  // controller launches on the same clock, so no synchroniser here
  always_ff @(posedge reference_clock_input_i or negedge resetn_i) begin
    if (!resetn_i) begin
      line_tx_sym_o    <= `PMC_SYM_IDLE;
      line_tx_active_o <= 1'b0;
    end else begin
      line_tx_active_o <= tx_en_i;
      if (!tx_en_i) begin
        line_tx_sym_o <= `PMC_SYM_IDLE;
      end else if (enc_byp_reg) begin
        line_tx_sym_o <= {tx_er_i, txd_i};
      end else if (tx_er_i) begin
        line_tx_sym_o <= `PMC_SYM_HALT;
      end else begin
        line_tx_sym_o <= pmc_encode(txd_i);
      end
    end
  end

  // ---------------------------------------------------------------
  // receive path, line side
  // ---------------------------------------------------------------
  assign dec_res = pmc_decode(line_rx_sym_i);
  always_comb begin
    if (dec_byp_reg) begin
      push_item = '{fifth: line_rx_sym_i[4], nib: line_rx_sym_i[3:0]};
    end else begin
      push_item = '{fifth: dec_res[4], nib: dec_res[3:0]};
    end
  end

  // line source stalls on line_rx_ready_o when the fifo is full
  pmc_async_fifo #(
    .WIDTH ($bits(pmc_rx_item_t)),
    .DEPTH (`PMC_FIFO_DEPTH)
  ) u_rx_fifo (
    .wclk_i   (clk_i),
    .rclk_i   (rx_clk_n),
    .resetn_i (resetn_i),
    .wdata_i  (push_item),
    .wvalid_i (line_rx_valid_i),
    .wready_o (line_rx_ready_o),
    .rdata_o  (pop_item),
    .rvalid_o (pop_valid),
    .rready_i (1'b1)
  );

  // ---------------------------------------------------------------
  // receive path, controller side, falling edges except col_o
  // ---------------------------------------------------------------
  always_ff @(negedge reference_clock_input_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rxd_o   <= '0;
      rx_dv_o <= 1'b0;
      rx_er_o <= 1'b0;
    end else begin
      rx_dv_o <= pop_valid;
      rxd_o   <= pop_valid ? pop_item.nib : '0;
      rx_er_o <= pop_valid && pop_item.fifth;
    end
  end

  always_ff @(negedge reference_clock_input_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crs_sync_reg <= '0;
      crs_o        <= 1'b0;
    end else begin
      crs_sync_reg <= {crs_sync_reg[1:0], line_rx_carrier_i};
      if (crs_sync_reg[1] == crs_sync_reg[2]) begin
        crs_o <= crs_sync_reg[2];
      end
    end
  end

  // half-cycle path from crs_o; tolerable at this clock rate
  always_ff @(posedge reference_clock_input_i or negedge resetn_i) begin
    if (!resetn_i) begin
      col_o <= 1'b0;
    end else begin
      col_o <= tx_en_i && crs_o;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // rising edge snapshot; receive outputs may only move at the fall
  logic [5:0] rx_rise_reg;
  always_ff @(posedge reference_clock_input_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_rise_reg <= '0;
    end else begin
      rx_rise_reg <= {rx_er_o, rx_dv_o, rxd_o};
    end
  end

  sequence s_tx_data;
    tx_en_i && !tx_er_i && !enc_byp_reg;
  endsequence

  sequence s_tx_error;
    tx_en_i && tx_er_i && !enc_byp_reg;
  endsequence

  sequence s_crs_steady;
    (crs_sync_reg[2] == line_rx_carrier_i)[*4];
  endsequence

  a_tx_idle_sym: assert property (
    @(posedge reference_clock_input_i) disable iff (!resetn_i)
    !tx_en_i |=> line_tx_sym_o == `PMC_SYM_IDLE && !line_tx_active_o)
    else $error("idle enable did not give idle symbol");

  a_tx_nibble_enc: assert property (
    @(posedge reference_clock_input_i) disable iff (!resetn_i)
    s_tx_data |=> line_tx_sym_o == pmc_encode($past(txd_i)) && line_tx_active_o)
    else $error("transmit nibble not encoded");

  a_tx_halt_sent: assert property (
    @(posedge reference_clock_input_i) disable iff (!resetn_i)
    s_tx_error |=> line_tx_sym_o == `PMC_SYM_HALT)
    else $error("transmit error did not send halt");

  a_tx_bypass_sym: assert property (
    @(posedge reference_clock_input_i) disable iff (!resetn_i)
    tx_en_i && enc_byp_reg |=> line_tx_sym_o == {$past(tx_er_i), $past(txd_i)})
    else $error("bypass symbol wrong");

  a_rx_dv_follow: assert property (
    @(negedge reference_clock_input_i) disable iff (!resetn_i)
    pop_valid |=> rx_dv_o ##1 (rx_dv_o == $past(pop_valid)))
    else $error("data valid not following fifo");

  a_rx_nibble_out: assert property (
    @(negedge reference_clock_input_i) disable iff (!resetn_i)
    pop_valid |=> rxd_o == $past(pop_item.nib) && rx_dv_o)
    else $error("receive nibble lost");

  a_rx_stable_rise: assert property (
    @(negedge reference_clock_input_i) disable iff (!resetn_i)
    {rx_er_o, rx_dv_o, rxd_o} == rx_rise_reg)
    else $error("receive outputs moved on rising edge");

  a_rx_code_err: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    line_rx_valid_i && !dec_byp_reg && dec_res[4] |-> push_item.fifth)
    else $error("undecodable symbol not flagged");

  a_rx_bypass_bit: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    dec_byp_reg |-> push_item == pmc_rx_item_t'(line_rx_sym_i))
    else $error("bypass receive symbol altered");

  a_crs_tracks: assert property (
    @(negedge reference_clock_input_i) disable iff (!resetn_i)
    s_crs_steady |=> crs_o == $past(line_rx_carrier_i, 2))
    else $error("carrier sense not following activity");

  a_col_level: assert property (
    @(posedge reference_clock_input_i) disable iff (!resetn_i)
    ##1 col_o == $past(tx_en_i && crs_o))
    else $error("collision level wrong");
endmodule : pmc_mii_port

// [bench/pmc_ctrl_model.sv]
/*
  controller model facing the port: drives transmit inputs after rising
  transmit clock, collects received items on rising receive clock.
  assumes the bench calls put() and reads got.
*/
`timescale 1ns/1ps
module pmc_ctrl_model
  import pmc_pkg::*;
(
  input  wire logic              tx_clk_i,
  output pmc_pkg::pmc_nib_t      txd_o,
  output logic                   tx_en_o,
  output logic                   tx_er_o,
  input  wire logic              rx_clk_i,
  input  wire pmc_pkg::pmc_nib_t rxd_i,
  input  wire logic              rx_dv_i,
  input  wire logic              rx_er_i
);
  pmc_rx_item_t got[$];

  initial begin
    txd_o = '0;
    tx_en_o = 1'b0;
    tx_er_o = 1'b0;
  end

  // -----------------------------------------------------------------
  // transmit and receive sides
  // -----------------------------------------------------------------
  task automatic put(input logic en, input logic er, input pmc_nib_t n);
    @(posedge tx_clk_i);
    #1;
    tx_en_o = en;
    // not enabled: flip data so stale values never pass for valid
    txd_o = en ? n : ~txd_o;
    tx_er_o = en ? er : ~tx_er_o;
  endtask : put

  always @(posedge rx_clk_i) begin
    if (rx_dv_i) begin
      got.push_back({rx_er_i, rxd_i});
    end
  end
endmodule : pmc_ctrl_model

// [bench/tb_pmc_mii_port.sv]
/*
  bench for the controller-side port: line side driven here, controller
  side by pmc_ctrl_model. assumes pmc_pkg and pmc_map.svh are compiled.
*/
`timescale 1ns/1ps
module tb_pmc_mii_port;
  import pmc_pkg::*;
  logic     clk_i, resetn_i, reference_clock_input_i, ref_run;
  logic     encoder_bypass_i, decoder_bypass_i, tx_en_i, tx_er_i, tx_clk_o, rx_clk_o;
  logic     rx_dv_o, rx_er_o, crs_o, col_o, line_tx_active_o;
  logic     line_rx_valid_i, line_rx_ready_o, line_rx_carrier_i;
  pmc_nib_t txd_i, rxd_o;
  pmc_sym_t line_tx_sym_o, line_rx_sym_i;
  int       fails = 0;
  int       checks = 0;
  pmc_sym_t enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  // -----------------------------------------------------------------
  // clocks and instances
  // -----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    reference_clock_input_i = 1'b0;
    #7;
    forever #15 if (ref_run) reference_clock_input_i = ~reference_clock_input_i;
  end

  pmc_mii_port pmc_mii_port_inst (.clk_i, .resetn_i, .reference_clock_input_i,
    .encoder_bypass_i, .decoder_bypass_i, .tx_clk_o, .txd_i, .tx_en_i, .tx_er_i,
    .rx_clk_o, .rxd_o, .rx_dv_o, .rx_er_o, .crs_o, .col_o, .line_tx_sym_o,
    .line_tx_active_o, .line_rx_sym_i, .line_rx_valid_i, .line_rx_ready_o,
    .line_rx_carrier_i);
  pmc_ctrl_model pmc_ctrl_model_inst (.tx_clk_i(tx_clk_o), .txd_o(txd_i), .tx_en_o(tx_en_i),
    .tx_er_o(tx_er_i), .rx_clk_i(rx_clk_o), .rxd_i(rxd_o), .rx_dv_i(rx_dv_o),
    .rx_er_i(rx_er_o));

  always @(rxd_o or rx_dv_o or rx_er_o or crs_o) begin
    if (resetn_i === 1'b1 && rx_clk_o !== 1'b0) begin
      check("rx change on falling edge", 6'h0, 6'h1);
    end
  end

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic check(input string what, input logic [5:0] exp, input logic [5:0] seen);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic hang(input string what);
    check(what, 6'h0, 6'h3f);
    summarize();
  endtask : hang

  task automatic tx_chk(input logic en, input logic er, input pmc_nib_t n, input pmc_sym_t s);
    pmc_ctrl_model_inst.put(en, er, n);
    @(posedge reference_clock_input_i);
    #1;
    check("line tx symbol", s, line_tx_sym_o);
    check("line tx active", en, line_tx_active_o);
    check("tx clock", reference_clock_input_i, tx_clk_o);
    check("rx clock", reference_clock_input_i, rx_clk_o);
  endtask : tx_chk

  // called at a clk_i edge, returns at the edge that takes the symbol
  task automatic push(input pmc_sym_t s);
    int n = 0;
    #1;
    line_rx_sym_i = s;
    line_rx_valid_i = 1'b1;
    while (line_rx_ready_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
      if (++n > 100) hang("line ready");
    end
    @(posedge clk_i);
  endtask : push

  task automatic idle();
    #1;
    line_rx_valid_i = 1'b0;
    line_rx_sym_i = ~line_rx_sym_i;
  endtask : idle

  task automatic wait_got(input int cnt);
    int n = 0;
    while (pmc_ctrl_model_inst.got.size() < cnt) begin
      @(posedge clk_i);
      if (++n > 400) hang("receive count");
    end
    repeat (8) @(posedge clk_i);
    check("rx count", 6'(cnt), 6'(pmc_ctrl_model_inst.got.size()));
  endtask : wait_got

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_tx();
    for (int i = 0; i < 16; i++) begin
      tx_chk(1'b1, 1'b0, 4'(i), enc[i]);
    end
    tx_chk(1'b1, 1'b1, 4'h7, `PMC_SYM_HALT);
    tx_chk(1'b0, 1'b1, 4'h2, `PMC_SYM_IDLE);
    encoder_bypass_i = 1'b1;
    repeat (8) @(posedge reference_clock_input_i);
    tx_chk(1'b1, 1'b1, 4'h5, 5'h15);
    tx_chk(1'b1, 1'b0, 4'h3, 5'h03);
    encoder_bypass_i = 1'b0;
    tx_chk(1'b0, 1'b0, 4'h0, `PMC_SYM_IDLE);
  endtask : t_tx

  task automatic t_rx();
    pmc_ctrl_model_inst.got.delete();
    @(posedge clk_i);
    for (int i = 0; i < 16; i++) begin
      push(enc[i]);
    end
    push(5'h00);
    idle();
    wait_got(17);
    for (int i = 0; i < 16; i++) begin
      check("rx nibble", {2'b00, 4'(i)}, pmc_ctrl_model_inst.got[i]);
    end
    check("rx coding error", 6'h10, pmc_ctrl_model_inst.got[16]);
    #1;
    decoder_bypass_i = 1'b1;
    pmc_ctrl_model_inst.got.delete();
    repeat (8) @(posedge clk_i);
    push(5'h15);
    push(5'h00);
    idle();
    wait_got(2);
    check("bypass symbol", 6'h15, pmc_ctrl_model_inst.got[0]);
    check("bypass symbol", 6'h00, pmc_ctrl_model_inst.got[1]);
    #1;
    decoder_bypass_i = 1'b0;
  endtask : t_rx

  task automatic t_full();
    pmc_ctrl_model_inst.got.delete();
    // reference frozen so nothing drains and the buffer has to refuse
    ref_run = 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 32; i++) begin
      push(enc[i % 16]);
    end
    #1;
    check("ready when full", 6'h0, line_rx_ready_o);
    repeat (3) @(posedge clk_i);
    idle();
    check("ready held low", 6'h0, line_rx_ready_o);
    ref_run = 1'b1;
    wait_got(32);
    for (int i = 0; i < 32; i++) begin
      check("drained nibble", {2'b00, 4'(i % 16)}, pmc_ctrl_model_inst.got[i]);
    end
  endtask : t_full

  task automatic t_crs_col();
    #1;
    line_rx_carrier_i = 1'b1;
    repeat (8) @(posedge reference_clock_input_i);
    check("carrier on", 6'h1, crs_o);
    tx_chk(1'b1, 1'b0, 4'h1, 5'h09);
    check("collision on", 6'h1, col_o);
    tx_chk(1'b0, 1'b0, 4'h1, `PMC_SYM_IDLE);
    check("collision off", 6'h0, col_o);
    line_rx_carrier_i = 1'b0;
    repeat (8) @(posedge reference_clock_input_i);
    #1;
    check("carrier off", 6'h0, crs_o);
  endtask : t_crs_col

  initial begin
    resetn_i = 1'b0;
    ref_run = 1'b1;
    encoder_bypass_i = 1'b0;
    decoder_bypass_i = 1'b0;
    line_rx_sym_i = '0;
    line_rx_valid_i = 1'b0;
    line_rx_carrier_i = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    t_tx();
    t_rx();
    t_full();
    t_crs_col();
    summarize();
  end
endmodule : tb_pmc_mii_port
